// ---- hdl/lcd_cmd_pkg.sv ----
// Constants, field layouts and states of the serial command port of the LCD column driver.
// Assumes one 100 MHz clock; the bus pins are sampled as synchronous inputs.
package lcd_cmd_pkg;
   // serial byte framing
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   localparam logic [3:0] BIT_ONE = 4'h1;
   localparam logic [2:0] BIT_MSB = 3'h7;
   localparam int CMD_FLAG_BIT = 7;
   localparam int RW_BIT = 0;
   // upper six address bits; the lowest bit comes from the select pin
   localparam logic [5:0] ADDR_BASE = 6'h1E;
   // field widths
   localparam int COL_W = 6;
   localparam int SUB_W = 4;
   localparam int BANK_W = 2;
   localparam int BYTE_W = 8;
   localparam int BUF_W = BANK_W + COL_W + BYTE_W;
   // column pointer range
   localparam logic [5:0] COL_FIRST = 6'h00;
   localparam logic [5:0] COL_LAST = 6'h27;
   localparam logic [3:0] SUB_ONE = 4'h1;
   // opcode prefixes below the continuation flag
   localparam logic [1:0] OP_MODE = 2'h2;
   localparam logic [2:0] OP_SUBADDR = 3'h6;
   localparam logic [2:0] OP_MEMACC = 3'h7;
   localparam logic [3:0] MEMACC_LIMIT = 4'hC;
   // multiplex field codes and row counts
   localparam logic [1:0] MUX_8 = 2'h1;
   localparam logic [1:0] MUX_16 = 2'h2;
   localparam logic [1:0] MUX_24 = 2'h3;
   localparam logic [1:0] MUX_32 = 2'h0;
   localparam logic [5:0] ROWS_8 = 6'h08;
   localparam logic [5:0] ROWS_16 = 6'h10;
   localparam logic [5:0] ROWS_24 = 6'h18;
   localparam logic [5:0] ROWS_32 = 6'h20;
   // power-on values
   localparam logic [3:0] SUB_RESET = 4'h0;
   localparam logic [5:0] COL_RESET = 6'h00;
   localparam logic [1:0] MUX_RESET = 2'h0;
   localparam logic [1:0] BANK_RESET = 2'h0;
   localparam logic [1:0] ORDER_CHAR = 2'h0;
   localparam logic [1:0] STATUS_BLANK = 2'h0;
   localparam logic SYSTYPE_RESET = 1'b0;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   // two-entry buffer occupancy
   localparam logic [1:0] CNT_EMPTY = 2'h0;
   localparam logic [1:0] CNT_FULL = 2'h2;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_ADDR,
      PH_CMD,
      PH_WDATA,
      PH_RDATA,
      PH_IGNORE
   } phase_e;
endpackage : lcd_cmd_pkg

// ---- hdl/stream_if.sv ----
// Valid/ready word carrier between the command port and its write buffer.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface stream_if;
   logic valid;
   logic ready;
   logic [lcd_cmd_pkg::BUF_W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : stream_if

// ---- hdl/two_entry_buffer.sv ----
// Two-entry word buffer with valid/ready on both sides.
// Assumes one clock and active-low asynchronous reset.
`timescale 1ns/10ps
module two_entry_buffer (
   input wire logic clk, // system clock
   input wire logic nrst, // async reset, active low
   stream_if.snk fill, // filling side
   stream_if.src drain // draining side
);
   import lcd_cmd_pkg::*;

   logic [BUF_W-1:0] memReg [2];
   logic wrPtrReg;
   logic rdPtrReg;
   logic [1:0] countReg;
   logic pushNow;
   logic popNow;

   assign fill.ready = (countReg != CNT_FULL);
   assign drain.valid = (countReg != CNT_EMPTY);
   assign drain.data = memReg[rdPtrReg];
   assign pushNow = fill.valid && fill.ready;
   assign popNow = drain.valid && drain.ready;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         memReg[0] <= '0;
         memReg[1] <= '0;
      end else if (pushNow) begin
         memReg[wrPtrReg] <= fill.data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wrPtrReg <= 1'b0;
         rdPtrReg <= 1'b0;
         countReg <= CNT_EMPTY;
      end else begin
         if (pushNow) begin
            wrPtrReg <= ~wrPtrReg;
         end
         if (popNow) begin
            rdPtrReg <= ~rdPtrReg;
         end
         if (pushNow && !popNow) begin
            countReg <= countReg + 2'h1;
         end else if (popNow && !pushNow) begin
            countReg <= countReg - 2'h1;
         end
      end
   end
endmodule : two_entry_buffer

// ---- hdl/lcd_column_i2c_command_port.sv ----
// Serial-bus slave front end of an LCD column driver: address match, command decode,
// display byte streaming to and from an external display RAM.
// Assumes scl/sda levels are already synchronous to clk and far slower than it;
// the RAM answers a read one clock after the request and accepts writes by valid/ready.
//
// Behaviour
// - answer only slave address 011110 followed by the select pin level
// - matching devices acknowledge the address; others ignore the rest of the transfer
// - read/write bit zero selects write mode with command bytes following
// - acknowledge every command byte regardless of hardware subaddress
// - acknowledge display bytes only when subaddress counter matches the pins
// - read/write bit one makes the device transmit display RAM bytes
// - on a missing master acknowledge stop sending and release the data line
// - each display byte uses the current column/bank pointer in the selected device
// - after each display byte advance the pointer; a wrap past column 39 advances the subaddress counter
// - command bit 7 set means another command follows, clear means data follows
// - commands are decoded only in write mode; read mode is all data
// - decode column load, mode setup, subaddress select, memory access, top bank
// - memory access with low nibble twelve or more acts as top bank
// - memory access loads access order and bank select fields
// - top bank command stores the two-bit bank shown at the top row
// - multiplex field 01, 10, 11, 00 gives 8, 16, 24, 32 rows
// - subaddress select copies four bits into the subaddress counter
// - top bank value is a plain binary bank number 0 to 3
// - display data moves only while subaddress counter equals the pins
// - reset clears counter and pointer, 32 rows, bank 0, character mode
`timescale 1ns/10ps
module lcd_column_i2c_command_port (
   input wire logic clk, // system clock, 100 MHz
   input wire logic nrst, // async reset, active low
   input wire logic sclIn, // serial clock level
   output logic sclOut, // serial clock drive value, always low
   output logic sclOe, // high while holding the clock low
   input wire logic sdaIn, // serial data level
   output logic sdaOut, // serial data drive value, always low
   output logic sdaOe, // high while pulling data low
   input wire logic addrLsbSelectPin, // lowest slave address bit
   input wire logic [lcd_cmd_pkg::SUB_W-1:0] hwSubaddrPins, // hardware subaddress
   output logic ramWrEn, // write word valid
   input wire logic ramWrReady, // ram takes the write word
   output logic [lcd_cmd_pkg::BANK_W-1:0] ramWrBank, // write bank
   output logic [lcd_cmd_pkg::COL_W-1:0] ramWrCol, // write column
   output logic [lcd_cmd_pkg::BYTE_W-1:0] ramWrData, // write byte
   output logic ramRdEn, // read request pulse
   output logic [lcd_cmd_pkg::BANK_W-1:0] ramRdBank, // read bank
   output logic [lcd_cmd_pkg::COL_W-1:0] ramRdCol, // read column
   input wire logic [lcd_cmd_pkg::BYTE_W-1:0] ramRdData, // read byte, one clock later
   output logic [lcd_cmd_pkg::SUB_W-1:0] subaddrCount, // subaddress counter
   output logic [1:0] muxRate, // {mux_rate_hi, mux_rate_lo}
   output logic [5:0] muxRows, // decoded row count
   output logic [1:0] displayStatus, // display status field
   output logic systemType, // system type bit
   output logic [1:0] accessOrder, // {access_order_hi, access_order_lo}
   output logic [lcd_cmd_pkg::BANK_W-1:0] bankSelect, // {bank_select_hi, bank_select_lo}
   output logic [lcd_cmd_pkg::BANK_W-1:0] topBank // {top_bank_hi, top_bank_lo}
);
   import lcd_cmd_pkg::*;

   phase_e phaseReg;
   logic sclPrevReg;
   logic sdaPrevReg;
   logic [3:0] bitCntReg;
   logic [7:0] shiftReg;
   logic ackReg;
   logic sdaDriveReg;
   logic sclHoldReg;
   logic [COL_W-1:0] colReg;
   logic [SUB_W-1:0] subCntReg;
   logic [1:0] muxRateReg;
   logic [5:0] muxRowsReg;
   logic [1:0] statusReg;
   logic sysTypeReg;
   logic [1:0] orderReg;
   logic [BANK_W-1:0] bankReg;
   logic [BANK_W-1:0] topBankReg;
   logic rdReqReg;
   logic rdWaitReg;
   logic txMatchReg;
   logic [7:0] txByteReg;
   logic wrPendReg;
   logic [BUF_W-1:0] wrWordReg;

   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;
   logic byteDone;
   logic ackClock;
   logic [7:0] rxByte;
   logic addrMatch;
   logic subMatch;
   logic dataByte;

   stream_if toBuf();
   stream_if fromBuf();

   // edges are taken from the previous sample; our own drive changes only while scl is low
   assign sclRise = !sclPrevReg && sclIn;
   assign sclFall = sclPrevReg && !sclIn;
   assign startCond = sclPrevReg && sclIn && sdaPrevReg && !sdaIn;
   assign stopCond = sclPrevReg && sclIn && !sdaPrevReg && sdaIn;
   assign rxByte = {shiftReg[6:0], sdaIn};
   assign byteDone = sclRise && (bitCntReg == BIT_LAST) && (phaseReg != PH_IDLE)
      && (phaseReg != PH_IGNORE);
   assign ackClock = sclRise && (bitCntReg == BIT_ACK);
   assign addrMatch = (rxByte[7:1] == {ADDR_BASE, addrLsbSelectPin});
   assign subMatch = (subCntReg == hwSubaddrPins);
   assign dataByte = byteDone && ((phaseReg == PH_WDATA) || (phaseReg == PH_RDATA));

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sclPrevReg <= 1'b1;
         sdaPrevReg <= 1'b1;
      end else begin
         sclPrevReg <= sclIn;
         sdaPrevReg <= sdaIn;
      end
   end

   // bit position within the nine-clock byte frame
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bitCntReg <= BIT_ZERO;
         shiftReg <= BYTE_RESET;
      end else if (startCond || stopCond) begin
         bitCntReg <= BIT_ZERO;
      end else if (sclRise) begin
         shiftReg <= rxByte;
         if (bitCntReg == BIT_ACK) begin
            bitCntReg <= BIT_ZERO;
         end else begin
            bitCntReg <= bitCntReg + BIT_ONE;
         end
      end
   end

   // transfer phase
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phaseReg <= PH_IDLE;
      end else if (startCond) begin
         phaseReg <= PH_ADDR;
      end else if (stopCond) begin
         phaseReg <= PH_IDLE;
      end else if (byteDone) begin
         case (phaseReg)
            PH_ADDR: begin
               if (!addrMatch) begin
                  phaseReg <= PH_IGNORE;
               end else if (rxByte[RW_BIT]) begin
                  phaseReg <= PH_RDATA;
               end else begin
                  phaseReg <= PH_CMD;
               end
            end
            PH_CMD: begin
               if (!rxByte[CMD_FLAG_BIT]) begin
                  phaseReg <= PH_WDATA;
               end
            end
            default: begin
               phaseReg <= phaseReg;
            end
         endcase
      end else if (ackClock && (phaseReg == PH_RDATA) && sdaIn) begin
         phaseReg <= PH_IGNORE;
      end
   end

   // acknowledge decision, taken when the eighth bit arrives
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ackReg <= 1'b0;
      end else if (byteDone) begin
         case (phaseReg)
            PH_ADDR: ackReg <= addrMatch;
            PH_CMD: ackReg <= 1'b1;
            PH_WDATA: ackReg <= subMatch;
            default: ackReg <= 1'b0;
         endcase
      end
   end

   // data line drive, changed on scl falling edges and cleared on start or stop
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sdaDriveReg <= 1'b0;
      end else if (startCond || stopCond) begin
         sdaDriveReg <= 1'b0;
      end else if (sclFall) begin
         if (bitCntReg == BIT_ACK) begin
            sdaDriveReg <= ackReg;
         end else if ((phaseReg == PH_RDATA) && txMatchReg) begin
            sdaDriveReg <= !txByteReg[BIT_MSB - bitCntReg[2:0]];
         end else begin
            sdaDriveReg <= 1'b0;
         end
      end
   end

   assign sdaOut = 1'b0;
   assign sdaOe = sdaDriveReg;
   assign sclOut = 1'b0;
   assign sclOe = sclHoldReg;

   // command decode and stored mode fields
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         muxRateReg <= MUX_RESET;
         muxRowsReg <= ROWS_32;
         statusReg <= STATUS_BLANK;
         sysTypeReg <= SYSTYPE_RESET;
         orderReg <= ORDER_CHAR;
         bankReg <= BANK_RESET;
         topBankReg <= BANK_RESET;
      end else if (byteDone && (phaseReg == PH_CMD) && rxByte[6]) begin
         if (rxByte[6:5] == OP_MODE) begin
            muxRateReg <= rxByte[4:3];
            statusReg <= rxByte[2:1];
            sysTypeReg <= rxByte[0];
            case (rxByte[4:3])
               MUX_8: muxRowsReg <= ROWS_8;
               MUX_16: muxRowsReg <= ROWS_16;
               MUX_24: muxRowsReg <= ROWS_24;
               MUX_32: muxRowsReg <= ROWS_32;
               default: muxRowsReg <= ROWS_32;
            endcase
         end else if (rxByte[6:4] == OP_MEMACC) begin
            if (rxByte[3:0] >= MEMACC_LIMIT) begin
               topBankReg <= rxByte[1:0];
            end else begin
               orderReg <= rxByte[3:2];
               bankReg <= rxByte[1:0];
            end
         end
      end
   end

   // column pointer and subaddress counter; a column wrap moves on to the next device
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         colReg <= COL_RESET;
         subCntReg <= SUB_RESET;
      end else if (byteDone && (phaseReg == PH_CMD)) begin
         if (!rxByte[6]) begin
            colReg <= rxByte[5:0];
         end else if (rxByte[6:4] == OP_SUBADDR) begin
            subCntReg <= rxByte[3:0];
         end
      end else if (dataByte) begin
         if (colReg == COL_LAST) begin
            colReg <= COL_FIRST;
            subCntReg <= subCntReg + SUB_ONE;
         end else begin
            colReg <= colReg + 6'h01;
         end
      end
   end

   // read fetch: first byte after the address, then after each master acknowledge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdReqReg <= 1'b0;
         rdWaitReg <= 1'b0;
         txMatchReg <= 1'b0;
         txByteReg <= BYTE_RESET;
      end else begin
         rdReqReg <= (byteDone && (phaseReg == PH_ADDR) && addrMatch && rxByte[RW_BIT])
            || (ackClock && (phaseReg == PH_RDATA) && !sdaIn);
         rdWaitReg <= rdReqReg;
         if (rdReqReg) begin
            txMatchReg <= subMatch;
         end
         if (rdWaitReg) begin
            txByteReg <= ramRdData;
         end
      end
   end

   assign ramRdEn = rdReqReg;
   assign ramRdBank = bankReg;
   assign ramRdCol = colReg;

   // write word waits here until the buffer takes it; the bus clock is held meanwhile
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wrPendReg <= 1'b0;
         wrWordReg <= '0;
      end else if (byteDone && (phaseReg == PH_WDATA) && subMatch) begin
         wrPendReg <= 1'b1;
         wrWordReg <= {bankReg, colReg, rxByte};
      end else if (toBuf.ready) begin
         wrPendReg <= 1'b0;
      end
   end

   // stretch only starts with scl already low, so the master sees a clean hold
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sclHoldReg <= 1'b0;
      end else if (!wrPendReg) begin
         sclHoldReg <= 1'b0;
      end else if (sclFall) begin
         sclHoldReg <= 1'b1;
      end
   end

   assign toBuf.valid = wrPendReg;
   assign toBuf.data = wrWordReg;
   assign fromBuf.ready = ramWrReady;
   assign ramWrEn = fromBuf.valid;
   assign ramWrBank = fromBuf.data[BUF_W-1 -: BANK_W];
   assign ramWrCol = fromBuf.data[BYTE_W +: COL_W];
   assign ramWrData = fromBuf.data[BYTE_W-1:0];

   two_entry_buffer writeBuffer (
      .clk(clk),
      .nrst(nrst),
      .fill(toBuf),
      .drain(fromBuf)
   );

   assign subaddrCount = subCntReg;
   assign muxRate = muxRateReg;
   assign muxRows = muxRowsReg;
   assign displayStatus = statusReg;
   assign systemType = sysTypeReg;
   assign accessOrder = orderReg;
   assign bankSelect = bankReg;
   assign topBank = topBankReg;
endmodule : lcd_column_i2c_command_port

// ---- tb/lcd_cmd_port_properties.sv ----
// Port-level properties of the serial command port.
// Assumes it is bound onto the top module and sees only its ports.
`timescale 1ns/10ps
module lcd_cmd_port_checker (
   input wire logic clk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic sclIn, // clock wire level
   input wire logic sclOe, // clock hold
   input wire logic sdaOe, // data pull
   input wire logic ramWrEn, // write word valid
   input wire logic ramWrReady, // ram takes word
   input wire logic [lcd_cmd_pkg::BYTE_W-1:0] ramWrData, // write byte
   input wire logic [lcd_cmd_pkg::COL_W-1:0] ramWrCol, // write column
   input wire logic ramRdEn, // read pulse
   input wire logic [lcd_cmd_pkg::BANK_W-1:0] ramRdBank, // read bank
   input wire logic [lcd_cmd_pkg::COL_W-1:0] ramRdCol, // read column
   input wire logic [lcd_cmd_pkg::BANK_W-1:0] bankSelect, // bank select
   input wire logic [lcd_cmd_pkg::SUB_W-1:0] subaddrCount, // subaddress counter
   input wire logic [1:0] muxRate, // multiplex code
   input wire logic [5:0] muxRows, // row count
   input wire logic [1:0] accessOrder, // access order
   input wire logic [lcd_cmd_pkg::BANK_W-1:0] topBank // top bank
);
   import lcd_cmd_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   reset_state_a: assert property (disable iff (1'b0) $rose(nrst) |-> subaddrCount == 4'h0
      && muxRows == ROWS_32 && accessOrder == ORDER_CHAR && bankSelect == 2'h0
      && topBank == 2'h0) else $error("state not at power-on values");
   // checked from the second reset edge on: the flops are unknown before the first one
   reset_idle_a: assert property (disable iff (1'b0) !nrst ##1 !nrst
      |-> !sdaOe && !sclOe && !ramWrEn && !ramRdEn) else $error("outputs active in reset");
   mux_rows_a: assert property (muxRows == (muxRate == MUX_8 ? ROWS_8 :
      muxRate == MUX_16 ? ROWS_16 : muxRate == MUX_24 ? ROWS_24 : ROWS_32))
      else $error("row count does not match mux code");
   data_after_fall_a: assert property ($changed(sdaOe) |-> !$past(sclIn) && $past(sclIn, 2))
      else $error("data pull changed off the clock fall");
   read_pulse_a: assert property (ramRdEn |=> !ramRdEn)
      else $error("read request longer than one clock");
   read_bank_a: assert property (ramRdEn |-> ramRdBank == bankSelect
      && ramRdCol <= COL_LAST) else $error("read address outside the display ram");
   word_held_a: assert property (ramWrEn && !ramWrReady |=> ramWrEn
      && $stable(ramWrData) && $stable(ramWrCol)) else $error("stalled word lost");
   stretch_low_a: assert property ($rose(sclOe) |-> !sclIn)
      else $error("clock hold began while clock high");
   col_range_a: assert property ($rose(ramWrEn) |-> ramWrCol <= COL_LAST)
      else $error("write column beyond last column");
endmodule : lcd_cmd_port_checker

bind lcd_column_i2c_command_port lcd_cmd_port_checker chk (.clk, .nrst, .sclIn, .sclOe,
   .sdaOe, .ramWrEn, .ramWrReady, .ramWrData, .ramWrCol, .ramRdEn, .ramRdBank, .ramRdCol,
   .bankSelect, .subaddrCount, .muxRate, .muxRows, .accessOrder, .topBank);

// ---- tb/i2c_master_model.sv ----
// Behavioural bus master driving the serial command port.
// Assumes the bench resolves both open-drain wires; honours clock stretching.
`timescale 1ns/10ps
module i2c_master_model (
   input wire logic clk, // system clock
   input wire logic scl, // clock wire level
   input wire logic sda, // data wire level
   output logic sclLow, // pulls clock low
   output logic sdaLow // pulls data low
);
   initial begin
      sclLow = 1'b0;
      sdaLow = 1'b0;
   end
   task automatic half();
      repeat (6) @(posedge clk);
      #1;
   endtask : half
   // a slave may hold the clock low, so the high phase starts when the wire rises
   task automatic bit_cycle(input logic b, output logic s);
      int n;
      n = 0;
      sdaLow = !b;
      half();
      sclLow = 1'b0;
      while (!scl && n < 5000) begin
         @(posedge clk);
         n++;
      end
      half();
      s = sda;
      sclLow = 1'b1;
   endtask : bit_cycle
   task automatic start();
      sdaLow = 1'b0;
      half();
      sclLow = 1'b0;
      half();
      sdaLow = 1'b1;
      half();
      sclLow = 1'b1;
   endtask : start
   task automatic stop();
      sdaLow = 1'b1;
      half();
      sclLow = 1'b0;
      half();
      sdaLow = 1'b0;
      half();
   endtask : stop
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
      bit_cycle(1'b1, s);
      ack = !s;
   endtask : wbyte
   task automatic rbyte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cycle(1'b1, b[i]);
      bit_cycle(last, s);
   endtask : rbyte
endmodule : i2c_master_model

// ---- tb/testbench.sv ----
// Self-checking bench for the serial command port with a small display RAM model.
// Assumes the master model and the bound property checker.
`timescale 1ns/10ps
module testbench;
   import lcd_cmd_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic addrSel = 1'b0;
   logic [3:0] pins = 4'h5;
   logic ramReady = 1'b1;
   logic [7:0] rdData = 8'h00;
   logic [7:0] mem [256];
   logic sclOe, sdaOe, sclLow, sdaLow, ramWrEn, ramRdEn, systemType, ack;
   logic stretched = 1'b0;
   logic [1:0] wrBank, rdBank, muxRate, accessOrder, bankSelect, topBank, dispStat, code;
   logic [5:0] wrCol, rdCol, muxRows;
   logic [5:0] rows [4] = '{ROWS_32, ROWS_8, ROWS_16, ROWS_24};
   logic [7:0] wrData, rb;
   logic [3:0] subaddrCount;
   logic [15:0] m;
   wire scl = !(sclOe | sclLow);
   wire sda = !(sdaOe | sdaLow);
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   always #5 clk = ~clk;
   i2c_master_model bm (.clk(clk), .scl(scl), .sda(sda), .sclLow(sclLow), .sdaLow(sdaLow));
   lcd_column_i2c_command_port uut (.clk(clk), .nrst(nrst), .sclIn(scl), .sclOut(),
      .sclOe(sclOe), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .addrLsbSelectPin(addrSel),
      .hwSubaddrPins(pins), .ramWrEn(ramWrEn), .ramWrReady(ramReady), .ramWrBank(wrBank),
      .ramWrCol(wrCol), .ramWrData(wrData), .ramRdEn(ramRdEn), .ramRdBank(rdBank),
      .ramRdCol(rdCol), .ramRdData(rdData), .subaddrCount(subaddrCount), .muxRate(muxRate),
      .muxRows(muxRows), .displayStatus(dispStat), .systemType(systemType),
      .accessOrder(accessOrder), .bankSelect(bankSelect), .topBank(topBank));
   // unread cycles return the inverse of the last value, so stale data reads inverted one clock after a read and valid again on the next
   always @(posedge clk) begin
      if (ramWrEn && ramReady) mem[{wrBank, wrCol}] <= wrData;
      rdData <= ramRdEn ? mem[{rdBank, rdCol}] : ~rdData;
      if (sclOe) stretched <= 1'b1;
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] b[$], output logic [15:0] k);
      k = 16'h0000;
      bm.start();
      bm.wbyte(a, k[0]);
      foreach (b[i]) bm.wbyte(b[i], k[i+1]);
      bm.stop();
   endtask : wr
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      repeat (3) @(posedge clk);
      #1 nrst = 1'b1;
      @(posedge clk);
      #1;
      chk({subaddrCount, muxRate, muxRows, accessOrder, bankSelect, topBank}, {SUB_RESET,
         MUX_RESET, ROWS_32, ORDER_CHAR, BANK_RESET, BANK_RESET});
      $display("test reset finished");
      wr(8'h7A, '{8'hE3}, m);
      chk(m, 16'h0000);
      addrSel = 1'b1;
      wr(8'h7A, '{8'hE3}, m);
      chk({m, subaddrCount}, {16'h0003, 4'h3});
      wr(8'h78, '{8'hE7}, m);
      chk({m, subaddrCount}, {16'h0000, 4'h3});
      addrSel = 1'b0;
      $display("test address finished");
      ramReady = 1'b0;
      fork
         begin
            repeat (2500) @(posedge clk);
            #1 ramReady = 1'b1;
         end
      join_none
      // last command clears the flag, then bytes at columns 37..39 then 0 of next device
      wr(8'h78, '{8'hC8, 8'hE5, 8'hF9, 8'hFE, 8'h25, 8'hA1, 8'hA2, 8'hA3, 8'h5A}, m);
      chk(m, 16'h01FF);
      chk({muxRate, accessOrder, bankSelect, topBank}, {2'h1, 2'h2, 2'h1, 2'h2});
      chk({subaddrCount, stretched}, {4'h6, 1'b1});
      chk({mem[8'h65], mem[8'h66], mem[8'h67]}, 24'hA1A2A3);
      chk(mem[8'h40], 8'h00);
      $display("test write finished");
      wr(8'h78, '{8'hE5, 8'h25}, m);
      chk(m, 16'h0007);
      bm.start();
      bm.wbyte(8'h79, ack);
      chk(ack, 1'b1);
      bm.rbyte(1'b0, rb);
      chk(rb, 8'hA1);
      bm.rbyte(1'b1, rb);
      chk(rb, 8'hA2);
      bm.rbyte(1'b1, rb);
      chk(rb, 8'hFF);
      bm.stop();
      pins = 4'h9;
      bm.start();
      bm.wbyte(8'h79, ack);
      bm.rbyte(1'b1, rb);
      bm.stop();
      chk({ack, rb}, {1'b1, 8'hFF});
      // the unmatched read still moves the pointer past column 39 onto the next device
      chk(subaddrCount, 4'h6);
      pins = 4'h5;
      $display("test read finished");
      for (int k = 0; k < 4; k++) begin
         code = 2'(k + 1);
         wr(8'h78, '{8'h40 | (8'(code) << 3) | (8'(k) << 1) | 8'(code[0])}, m);
         chk({m, muxRate, muxRows}, {16'h0003, code, rows[code]});
         chk({dispStat, systemType}, {2'(k), code[0]});
      end
      wr(8'h78, '{8'hFC}, m);
      chk({topBank, accessOrder, bankSelect}, {2'h0, 2'h2, 2'h1});
      $display("test modes finished");
      give_verdict();
   end
endmodule : testbench
